// file: logic/ppdc_top.sv
// Purpose: gpio port A..D pin drive configuration: indirect subregisters, driver controls, pin interrupts
// Assumes: the cpu writes the port address register then accesses the port control register
// Notes: driver control outputs are registered, interrupt requests are one-cycle pulses
`timescale 1ns/1ns
module ppdc_top (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // cpu register access
    input wire ppdc_pkg::ppdc_req_t i_req,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic [7:0] o_addr_reg,
    // port pins and gpio output data
    input wire logic [7:0] i_port_a_pin,
    input wire logic [7:0] i_port_c_pin,
    input wire logic [7:0] i_gpio_out_a,
    input wire logic [7:0] i_gpio_out_b,
    input wire logic [7:0] i_gpio_out_c,
    input wire logic [7:0] i_gpio_out_d,
    // peripheral alternate function outputs
    input wire logic [7:0] i_alt_out_a,
    input wire logic [7:0] i_alt_out_b_one,
    input wire logic [7:0] i_alt_out_b_two,
    input wire logic [7:0] i_alt_out_c_one,
    input wire logic [7:0] i_alt_out_c_two,
    input wire logic i_alt_out_d_zero,
    // timer pin direction from timer configuration
    input wire logic i_timer0_pin_is_output,
    input wire logic i_timer1_pin_is_output,
    // shared interrupt sources and edge choice
    input wire logic i_low_voltage_detector,
    input wire logic i_comparator_out,
    input wire logic i_sel_lvd_on_pin7,
    input wire logic i_sel_comp_on_pin6,
    input wire logic [7:0] i_port_a_rising,
    // pin driver controls
    output logic [7:0] o_pin_out_a,
    output logic [7:0] o_pin_out_b,
    output logic [7:0] o_pin_out_c,
    output logic [7:0] o_pin_out_d,
    output ppdc_pkg::ppdc_drive_t o_drive_a,
    output ppdc_pkg::ppdc_drive_t o_drive_b,
    output ppdc_pkg::ppdc_drive_t o_drive_c,
    output ppdc_pkg::ppdc_drive_t o_drive_d,
    output logic o_port_a0_timer_in,
    output logic o_port_a6_timer_in,
    // interrupt request pulses
    output logic [7:0] o_irq_port_a,
    output logic [3:0] o_irq_port_c
);
    logic [7:0] addr_reg;
    logic [7:0] next_addr_reg;
    logic rd_pending;
    logic [1:0] rd_port;
    logic [1:0] next_rd_port;
    logic [7:0] bank_rdata [ppdc_pkg::PORT_COUNT];
    logic [7:0] alt_en [ppdc_pkg::PORT_COUNT];
    logic [7:0] choice_one [ppdc_pkg::PORT_COUNT];
    logic [7:0] open_drain [ppdc_pkg::PORT_COUNT];
    logic [7:0] high_drive [ppdc_pkg::PORT_COUNT];
    logic [7:0] gpio_out [ppdc_pkg::PORT_COUNT];
    logic [7:0] alt_one [ppdc_pkg::PORT_COUNT];
    logic [7:0] alt_two [ppdc_pkg::PORT_COUNT];
    logic [7:0] alt_active [ppdc_pkg::PORT_COUNT];
    logic [7:0] next_pin_out [ppdc_pkg::PORT_COUNT];
    logic [7:0] irq_src_a;
    logic [7:0] irq_a;
    logic [3:0] irq_c;

    // the address register is shared by all four ports
    always_comb begin
        next_addr_reg = addr_reg;
        next_rd_port = rd_port;
        if (i_req.addr_wr) begin
            next_addr_reg = i_req.wdata;
        end
        if (i_req.ctl_rd) begin
            next_rd_port = i_req.port;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            addr_reg <= ppdc_pkg::ADDR_RESET;
            rd_port <= ppdc_pkg::PORT_A;
            rd_pending <= 1'b0;
        end else begin
            addr_reg <= next_addr_reg;
            rd_port <= next_rd_port;
            rd_pending <= i_req.ctl_rd;
        end
    end

    // one subregister bank per port; port d resets its pin zero to open drain
    genvar p;
    generate
        for (p = 0; p < ppdc_pkg::PORT_COUNT; p++) begin : g_port
            ppdc_subreg_bank #(
                .OD_RESET((p == ppdc_pkg::PORT_D) ? ppdc_pkg::OPEN_DRAIN_RESET_D
                                                  : ppdc_pkg::OPEN_DRAIN_RESET_ABC)
            ) u_bank (
                .i_mclk(i_mclk),
                .i_reset(i_reset),
                .i_wr(i_req.ctl_wr && (i_req.port == 2'(p))),
                .i_index(addr_reg),
                .i_wdata(i_req.wdata),
                .i_rd(i_req.ctl_rd && (i_req.port == 2'(p))),
                .o_rdata(bank_rdata[p]),
                .o_alt_en(alt_en[p]),
                .o_choice_one(choice_one[p]),
                .o_open_drain(open_drain[p]),
                .o_high_drive(high_drive[p])
            );
        end
    endgenerate

    // gather per-port inputs into arrays so the driver logic is one loop
    always_comb begin
        gpio_out[ppdc_pkg::PORT_A] = i_gpio_out_a;
        gpio_out[ppdc_pkg::PORT_B] = i_gpio_out_b;
        gpio_out[ppdc_pkg::PORT_C] = i_gpio_out_c;
        gpio_out[ppdc_pkg::PORT_D] = i_gpio_out_d;
        alt_one[ppdc_pkg::PORT_A] = i_alt_out_a;
        alt_two[ppdc_pkg::PORT_A] = i_alt_out_a;
        alt_one[ppdc_pkg::PORT_B] = i_alt_out_b_one;
        alt_two[ppdc_pkg::PORT_B] = i_alt_out_b_two;
        alt_one[ppdc_pkg::PORT_C] = i_alt_out_c_one;
        alt_two[ppdc_pkg::PORT_C] = i_alt_out_c_two;
        alt_one[ppdc_pkg::PORT_D] = {7'h00, i_alt_out_d_zero};
        alt_two[ppdc_pkg::PORT_D] = {7'h00, i_alt_out_d_zero};
    end

    // alternate function activity per port
    always_comb begin
        // port a: enable alone activates the single function
        alt_active[ppdc_pkg::PORT_A] = alt_en[ppdc_pkg::PORT_A];
        // ports b and c: choice two plays no part, enable still required
        alt_active[ppdc_pkg::PORT_B] = alt_en[ppdc_pkg::PORT_B];
        alt_active[ppdc_pkg::PORT_C] = alt_en[ppdc_pkg::PORT_C];
        // port d: only pin zero has an alternate function
        alt_active[ppdc_pkg::PORT_D] = {7'h00, alt_en[ppdc_pkg::PORT_D][ppdc_pkg::PIN_ZERO]};
    end

    // output data mux: choice one picks between the two functions on b and c
    generate
        for (p = 0; p < ppdc_pkg::PORT_COUNT; p++) begin : g_mux
            always_comb begin
                next_pin_out[p] = (alt_active[p] & ((choice_one[p] & alt_two[p]) |
                                  (~choice_one[p] & alt_one[p]))) |
                                  (~alt_active[p] & gpio_out[p]);
            end
        end
    endgenerate

    // shared sources on port a pins 7 and 6, one chosen for each
    always_comb begin
        irq_src_a = i_port_a_pin;
        irq_src_a[ppdc_pkg::PIN_SEVEN] = i_sel_lvd_on_pin7 ? i_low_voltage_detector
                                                           : i_port_a_pin[ppdc_pkg::PIN_SEVEN];
        irq_src_a[ppdc_pkg::PIN_SIX] = i_sel_comp_on_pin6 ? i_comparator_out
                                                          : i_port_a_pin[ppdc_pkg::PIN_SIX];
    end

    ppdc_edge_irq #(
        .WIDTH(ppdc_pkg::PORT_WIDTH)
    ) u_irq_a (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_src(irq_src_a),
        .i_rising(i_port_a_rising),
        .i_both(1'b0),
        .o_irq(irq_a)
    );

    ppdc_edge_irq #(
        .WIDTH(ppdc_pkg::PORT_C_EDGE_PINS)
    ) u_irq_c (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_src(i_port_c_pin[ppdc_pkg::PORT_C_EDGE_PINS-1:0]),
        .i_rising('0),
        .i_both(1'b1),
        .o_irq(irq_c)
    );

    // registered outputs; the driver bundle carries open-drain and high drive untouched by
    // the alternate function, since both act on the pad driver itself
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_rdata <= ppdc_pkg::READ_ZERO;
            o_rvalid <= 1'b0;
            o_addr_reg <= ppdc_pkg::ADDR_RESET;
            o_pin_out_a <= '0;
            o_pin_out_b <= '0;
            o_pin_out_c <= '0;
            o_pin_out_d <= '0;
            o_drive_a <= '{alt_active: 8'h00, source_off: ppdc_pkg::OPEN_DRAIN_RESET_ABC,
                           high_drive: ppdc_pkg::HIGH_DRIVE_RESET};
            o_drive_b <= '{alt_active: 8'h00, source_off: ppdc_pkg::OPEN_DRAIN_RESET_ABC,
                           high_drive: ppdc_pkg::HIGH_DRIVE_RESET};
            o_drive_c <= '{alt_active: 8'h00, source_off: ppdc_pkg::OPEN_DRAIN_RESET_ABC,
                           high_drive: ppdc_pkg::HIGH_DRIVE_RESET};
            o_drive_d <= '{alt_active: 8'h00, source_off: ppdc_pkg::OPEN_DRAIN_RESET_D,
                           high_drive: ppdc_pkg::HIGH_DRIVE_RESET};
            o_port_a0_timer_in <= 1'b1;
            o_port_a6_timer_in <= 1'b1;
            o_irq_port_a <= '0;
            o_irq_port_c <= '0;
        end else begin
            o_rdata <= rd_pending ? bank_rdata[rd_port] : ppdc_pkg::READ_ZERO;
            o_rvalid <= rd_pending;
            o_addr_reg <= next_addr_reg;
            o_pin_out_a <= next_pin_out[ppdc_pkg::PORT_A];
            o_pin_out_b <= next_pin_out[ppdc_pkg::PORT_B];
            o_pin_out_c <= next_pin_out[ppdc_pkg::PORT_C];
            o_pin_out_d <= next_pin_out[ppdc_pkg::PORT_D];
            // set bit: source off (open drain); clear bit: push-pull
            o_drive_a <= '{alt_active: alt_active[ppdc_pkg::PORT_A], source_off: open_drain[ppdc_pkg::PORT_A],
                           high_drive: high_drive[ppdc_pkg::PORT_A]};
            o_drive_b <= '{alt_active: alt_active[ppdc_pkg::PORT_B], source_off: open_drain[ppdc_pkg::PORT_B],
                           high_drive: high_drive[ppdc_pkg::PORT_B]};
            o_drive_c <= '{alt_active: alt_active[ppdc_pkg::PORT_C], source_off: open_drain[ppdc_pkg::PORT_C],
                           high_drive: high_drive[ppdc_pkg::PORT_C]};
            o_drive_d <= '{alt_active: alt_active[ppdc_pkg::PORT_D], source_off: open_drain[ppdc_pkg::PORT_D],
                           high_drive: high_drive[ppdc_pkg::PORT_D]};
            // pin role on a0 and a6 comes only from the timer, not from port registers
            o_port_a0_timer_in <= ~i_timer0_pin_is_output;
            o_port_a6_timer_in <= ~i_timer1_pin_is_output;
            o_irq_port_a <= irq_a;
            o_irq_port_c <= irq_c;
        end
    end
endmodule // ppdc_top

// file: logic/ppdc_pkg.sv
// Purpose: shared constants and types for the port pin drive configuration block
// Assumes: four 8-bit ports A..D, indirect subregister access through an address register
// Notes: port select codes index the per-port subregister banks
package ppdc_pkg;
    localparam int unsigned PORT_COUNT = 4;
    localparam int unsigned PORT_WIDTH = 8;

    // port select codes
    localparam logic [1:0] PORT_A = 2'h0;
    localparam logic [1:0] PORT_B = 2'h1;
    localparam logic [1:0] PORT_C = 2'h2;
    localparam logic [1:0] PORT_D = 2'h3;

    // subregister indices written into the port address register
    localparam logic [7:0] SUB_ALT_FUNC = 8'h02;
    localparam logic [7:0] SUB_OPEN_DRAIN = 8'h03;
    localparam logic [7:0] SUB_HIGH_DRIVE = 8'h04;
    localparam logic [7:0] SUB_AF_CHOICE_ONE = 8'h07;
    localparam logic [7:0] SUB_AF_CHOICE_TWO = 8'h08;

    // reset values
    localparam logic [7:0] OPEN_DRAIN_RESET_ABC = 8'h00;
    localparam logic [7:0] OPEN_DRAIN_RESET_D = 8'h01;
    localparam logic [7:0] HIGH_DRIVE_RESET = 8'h00;
    localparam logic [7:0] ALT_FUNC_RESET = 8'h00;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // pin positions used by the special sources
    localparam int unsigned PIN_ZERO = 0;
    localparam int unsigned PIN_SIX = 6;
    localparam int unsigned PIN_SEVEN = 7;

    // edge detector sizing: port a eight pins, port c pins 0..3
    localparam int unsigned PORT_C_EDGE_PINS = 4;

    // register access request from the cpu side
    typedef struct packed {
        logic [1:0] port;
        logic addr_wr;
        logic ctl_wr;
        logic ctl_rd;
        logic [7:0] wdata;
    } ppdc_req_t;

    // per-pin driver control bundle for one port
    typedef struct packed {
        logic [7:0] alt_active;
        logic [7:0] source_off;
        logic [7:0] high_drive;
    } ppdc_drive_t;

    // one subregister bank state
    typedef enum logic [1:0] {
        PPDC_IDLE = 2'b00,
        PPDC_READ = 2'b01
    } ppdc_rd_state_t;
endpackage

// file: logic/ppdc_subreg_bank.sv
// Purpose: per-port storage for open-drain select, high-drive enable and alternate-function subregisters
// Assumes: writes arrive already decoded per port; the subregister is decoded here from i_index
// Notes: the read data come out of a register one cycle after the read strobe
`timescale 1ns/1ns
module ppdc_subreg_bank #(
    parameter logic [7:0] OD_RESET = 8'h00
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // write side
    input wire logic i_wr,
    input wire logic [7:0] i_index,
    input wire logic [7:0] i_wdata,
    // read side
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // stored values
    output logic [7:0] o_alt_en,
    output logic [7:0] o_choice_one,
    output logic [7:0] o_open_drain,
    output logic [7:0] o_high_drive
);
    logic [7:0] next_alt_en;
    logic [7:0] next_choice_one;
    logic [7:0] next_choice_two;
    logic [7:0] next_open_drain;
    logic [7:0] next_high_drive;
    logic [7:0] next_rdata;
    logic [7:0] choice_two;

    // indexed write and read mux; unknown indices read as zero
    always_comb begin
        next_alt_en = o_alt_en;
        next_choice_one = o_choice_one;
        next_choice_two = choice_two;
        next_open_drain = o_open_drain;
        next_high_drive = o_high_drive;
        next_rdata = o_rdata;
        if (i_wr) begin
            case (i_index)
                ppdc_pkg::SUB_ALT_FUNC: next_alt_en = i_wdata;
                ppdc_pkg::SUB_OPEN_DRAIN: next_open_drain = i_wdata;
                ppdc_pkg::SUB_HIGH_DRIVE: next_high_drive = i_wdata;
                ppdc_pkg::SUB_AF_CHOICE_ONE: next_choice_one = i_wdata;
                ppdc_pkg::SUB_AF_CHOICE_TWO: next_choice_two = i_wdata;
                default: next_alt_en = o_alt_en;
            endcase
        end
        if (i_rd) begin
            case (i_index)
                ppdc_pkg::SUB_ALT_FUNC: next_rdata = o_alt_en;
                ppdc_pkg::SUB_OPEN_DRAIN: next_rdata = o_open_drain;
                ppdc_pkg::SUB_HIGH_DRIVE: next_rdata = o_high_drive;
                ppdc_pkg::SUB_AF_CHOICE_ONE: next_rdata = o_choice_one;
                ppdc_pkg::SUB_AF_CHOICE_TWO: next_rdata = choice_two;
                default: next_rdata = ppdc_pkg::READ_ZERO;
            endcase
        end
    end

    // storage; the reset load differs per port through the parameter
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_alt_en <= ppdc_pkg::ALT_FUNC_RESET;
            o_choice_one <= ppdc_pkg::ALT_FUNC_RESET;
            choice_two <= ppdc_pkg::ALT_FUNC_RESET;
            o_open_drain <= OD_RESET;
            o_high_drive <= ppdc_pkg::HIGH_DRIVE_RESET;
            o_rdata <= ppdc_pkg::READ_ZERO;
        end else begin
            o_alt_en <= next_alt_en;
            o_choice_one <= next_choice_one;
            choice_two <= next_choice_two;
            o_open_drain <= next_open_drain;
            o_high_drive <= next_high_drive;
            o_rdata <= next_rdata;
        end
    end
endmodule // ppdc_subreg_bank

// file: logic/ppdc_edge_irq.sv
// Purpose: edge detector producing one-cycle interrupt request pulses per pin
// Assumes: pin levels are synchronous to the clock
// Notes: i_both makes a pin fire on either edge and overrides i_rising
`timescale 1ns/1ns
module ppdc_edge_irq #(
    parameter int unsigned WIDTH = 8
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // sources and edge choice
    input wire logic [WIDTH-1:0] i_src,
    input wire logic [WIDTH-1:0] i_rising,
    input wire logic i_both,
    // request pulses
    output logic [WIDTH-1:0] o_irq
);
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] next_irq;

    // per-pin edge select
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pin
            always_comb begin
                if (i_both) begin
                    next_irq[g] = i_src[g] ^ prev[g];
                end else if (i_rising[g]) begin
                    next_irq[g] = i_src[g] & ~prev[g];
                end else begin
                    next_irq[g] = ~i_src[g] & prev[g];
                end
            end
        end
    endgenerate

    // previous level tracks the source during reset, so a pin idling high gives no false edge after release
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            prev <= i_src;
            o_irq <= '0;
        end else begin
            prev <= i_src;
            o_irq <= next_irq;
        end
    end
endmodule // ppdc_edge_irq

// file: bench/ppdc_top_asserts.sv
// Purpose: port level timing checks for ppdc_top
// Assumes: one clock, synchronous reset, pins held quiet while reset is applied
// Notes: bound into ppdc_top at the foot of this file
`timescale 1ns/1ns
module ppdc_top_asserts (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // cpu side
    input wire ppdc_pkg::ppdc_req_t i_req,
    input wire logic o_rvalid,
    input wire logic [7:0] o_addr_reg,
    // pins and timer configuration
    input wire logic [7:0] i_port_a_pin,
    input wire logic [7:0] i_port_c_pin,
    input wire logic [7:0] i_port_a_rising,
    input wire logic i_timer0_pin_is_output,
    input wire logic i_timer1_pin_is_output,
    // driver controls and requests
    input wire ppdc_pkg::ppdc_drive_t o_drive_a,
    input wire ppdc_pkg::ppdc_drive_t o_drive_b,
    input wire ppdc_pkg::ppdc_drive_t o_drive_d,
    input wire logic o_port_a0_timer_in,
    input wire logic o_port_a6_timer_in,
    input wire logic [7:0] o_irq_port_a,
    input wire logic [3:0] o_irq_port_c
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);
    // a read strobe and its answer, split so the latency reads on its own
    sequence s_read_req;
        i_req.ctl_rd;
    endsequence
    sequence s_read_ans;
        ##2 o_rvalid;
    endsequence
    a_read_answer: assert property (s_read_req |-> s_read_ans)
        else $error("read not answered after two cycles");
    a_no_stray_rvalid: assert property (o_rvalid |-> $past(i_req.ctl_rd, 2))
        else $error("read valid without a read");
    a_addr_load: assert property (i_req.addr_wr |=> o_addr_reg == $past(i_req.wdata))
        else $error("address register not loaded");
    a_reset_values: assert property ($fell(i_reset) |-> o_drive_d.source_off == 8'h01
        && o_drive_a.source_off == 8'h00 && o_drive_b.high_drive == 8'h00)
        else $error("wrong driver controls after reset");
    // port b high drive only moves shortly after a control write
    a_drive_cause: assert property ($changed(o_drive_b.high_drive) |-> $past(i_req.ctl_wr)
        || $past(i_req.ctl_wr, 2) || $past(i_req.ctl_wr, 3))
        else $error("high drive changed without a write");
    a_port_c_edges: assert property (o_irq_port_c ==
        ($past(i_port_c_pin[3:0], 2) ^ $past(i_port_c_pin[3:0], 3)))
        else $error("port c request does not follow both edges");
    a_port_a_edges: assert property (o_irq_port_a[5:0] ==
        (($past(i_port_a_rising[5:0], 2) & $past(i_port_a_pin[5:0], 2) & ~$past(i_port_a_pin[5:0], 3))
        | (~$past(i_port_a_rising[5:0], 2) & ~$past(i_port_a_pin[5:0], 2) & $past(i_port_a_pin[5:0], 3))))
        else $error("port a request on wrong edge");
    a_timer_role: assert property (o_port_a0_timer_in == !$past(i_timer0_pin_is_output)
        && o_port_a6_timer_in == !$past(i_timer1_pin_is_output))
        else $error("timer pin role not from timer config");
    a_port_d_single: assert property (o_drive_d.alt_active[7:1] == 7'h00)
        else $error("port d alternate function beyond pin zero");
endmodule // ppdc_top_asserts

bind ppdc_top ppdc_top_asserts u_chk (.i_mclk, .i_reset, .i_req, .o_rvalid, .o_addr_reg, .i_port_a_pin,
    .i_port_c_pin, .i_port_a_rising, .i_timer0_pin_is_output, .i_timer1_pin_is_output, .o_drive_a,
    .o_drive_b, .o_drive_d, .o_port_a0_timer_in, .o_port_a6_timer_in, .o_irq_port_a, .o_irq_port_c);

// file: bench/ppdc_board_model.sv
// Purpose: board side of the port pins
// Assumes: pins are plain inputs to the block, no contention modelled
// Notes: levels move one clock after a request, never at the sampling instant
`timescale 1ns/1ns
module ppdc_board_model (
    // clock
    input wire logic i_mclk,
    // requested board levels
    input wire logic [7:0] i_level_a,
    input wire logic [7:0] i_level_c,
    // pin levels seen by the block
    output logic [7:0] o_pin_a,
    output logic [7:0] o_pin_c
);
    // board trace delay of one clock
    always_ff @(posedge i_mclk) begin
        o_pin_a <= i_level_a;
        o_pin_c <= i_level_c;
    end
endmodule // ppdc_board_model

// file: bench/port_pin_drive_config_test.sv
// Purpose: self-checking bench for ppdc_top
// Assumes: 250 MHz clock, reset held for 5 cycles
// Notes: read answers are checked against a queue by the monitor
`timescale 1ns/1ns
module port_pin_drive_config_test;
    logic i_mclk = 1'b0;
    logic i_reset = 1'b1;
    ppdc_pkg::ppdc_req_t req = '0;
    logic [7:0] rdata, addr_reg, irq_a, pin_a, pin_c, lvl_a = 8'h00, lvl_c = 8'h00, rising = 8'h00;
    logic [7:0] gpio [4];
    logic [7:0] alt [5];
    logic [7:0] pout [4];
    logic rvalid, t0 = 1'b0, t1 = 1'b0, sel7 = 1'b0, sel6 = 1'b0, low_voltage_detector = 1'b0, cmp = 1'b0;
    logic [3:0] irq_c;
    ppdc_pkg::ppdc_drive_t drv [4];
    logic [7:0] exp_q [$];
    int n_errors = 0, check_count = 0, cycles = 0, c_pulses = 0, a_pulses = 0, v_pulses = 0, k_pulses = 0;

    ppdc_board_model board (.i_mclk, .i_level_a(lvl_a), .i_level_c(lvl_c), .o_pin_a(pin_a), .o_pin_c(pin_c));
    ppdc_top uut (.i_mclk, .i_reset, .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid), .o_addr_reg(addr_reg),
        .i_port_a_pin(pin_a), .i_port_c_pin(pin_c), .i_gpio_out_a(gpio[0]), .i_gpio_out_b(gpio[1]),
        .i_gpio_out_c(gpio[2]), .i_gpio_out_d(gpio[3]), .i_alt_out_a(alt[0]), .i_alt_out_b_one(alt[1]),
        .i_alt_out_b_two(alt[2]), .i_alt_out_c_one(alt[3]), .i_alt_out_c_two(alt[4]),
        .i_alt_out_d_zero(alt[0][1]), .i_timer0_pin_is_output(t0), .i_timer1_pin_is_output(t1),
        .i_low_voltage_detector(low_voltage_detector), .i_comparator_out(cmp), .i_sel_lvd_on_pin7(sel7),
        .i_sel_comp_on_pin6(sel6), .i_port_a_rising(rising), .o_pin_out_a(pout[0]), .o_pin_out_b(pout[1]),
        .o_pin_out_c(pout[2]), .o_pin_out_d(pout[3]), .o_drive_a(drv[0]), .o_drive_b(drv[1]),
        .o_drive_c(drv[2]), .o_drive_d(drv[3]), .o_port_a0_timer_in(), .o_port_a6_timer_in(),
        .o_irq_port_a(irq_a), .o_irq_port_c(irq_c));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask
    // index then control access; on a read, data is the expected answer
    task automatic acc(input logic [1:0] port, input logic [7:0] idx, input logic [7:0] data, input logic rd);
        if (rd) exp_q.push_back(data);
        req <= '{port: port, addr_wr: 1'b1, ctl_wr: 1'b0, ctl_rd: 1'b0, wdata: idx};
        @(posedge i_mclk);
        req <= '{port: port, addr_wr: 1'b0, ctl_wr: !rd, ctl_rd: rd, wdata: rd ? 8'h00 : data};
        @(posedge i_mclk);
        req <= '0;
        @(posedge i_mclk);
    endtask

    initial begin
        forever #2 i_mclk = ~i_mclk;
    end
    // monitor: read answers, pulse counts, hang limit
    always @(posedge i_mclk) begin
        if (rvalid === 1'b1) check(rdata, exp_q.size() ? exp_q.pop_front() : 8'hxx);
        c_pulses += irq_c[0];
        a_pulses += irq_a[0];
        v_pulses += irq_a[7];
        k_pulses += irq_a[6];
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            report_and_stop();
        end
    end

    initial begin
        logic [7:0] od [4];
        logic [7:0] hd [4];
        logic [7:0] en;
        void'($urandom(32'hc15d948f));
        foreach (gpio[i]) gpio[i] = $urandom();
        foreach (alt[i]) alt[i] = $urandom();
        rising = $urandom();
        step(5);
        i_reset <= 1'b0;
        step(1);
        for (int p = 0; p < 4; p++) begin
            acc(p[1:0], ppdc_pkg::SUB_OPEN_DRAIN, (p == 3) ? 8'h01 : 8'h00, 1'b1);
            acc(p[1:0], ppdc_pkg::SUB_HIGH_DRIVE, 8'h00, 1'b1);
        end
        check(drv[3].source_off, 8'h01);
        $display("reset values done");
        // random settings, plus an unmapped index that must be ignored and read as zero
        for (int p = 0; p < 4; p++) begin
            od[p] = $urandom();
            hd[p] = $urandom();
            acc(p[1:0], ppdc_pkg::SUB_OPEN_DRAIN, od[p], 1'b0);
            acc(p[1:0], ppdc_pkg::SUB_HIGH_DRIVE, hd[p], 1'b0);
            acc(p[1:0], 8'h05, 8'hff, 1'b0);
        end
        step(3);
        for (int p = 0; p < 4; p++) begin
            check(drv[p].source_off, od[p]);
            check(drv[p].high_drive, hd[p]);
            acc(p[1:0], ppdc_pkg::SUB_OPEN_DRAIN, od[p], 1'b1);
            acc(p[1:0], ppdc_pkg::SUB_HIGH_DRIVE, hd[p], 1'b1);
            acc(p[1:0], 8'h05, 8'h00, 1'b1);
        end
        $display("subregister access done");
        // choice two set on b and c must not change anything
        en = $urandom();
        for (int p = 0; p < 4; p++) acc(p[1:0], ppdc_pkg::SUB_ALT_FUNC, en, 1'b0);
        acc(2'h1, ppdc_pkg::SUB_AF_CHOICE_ONE, 8'h0f, 1'b0);
        acc(2'h1, ppdc_pkg::SUB_AF_CHOICE_TWO, 8'h3c, 1'b0);
        acc(2'h2, ppdc_pkg::SUB_AF_CHOICE_TWO, 8'hff, 1'b0);
        t0 <= 1'b1;
        t1 <= 1'b1;
        step(3);
        check(drv[0].alt_active, en);
        check(pout[0], (en & alt[0]) | (~en & gpio[0]));
        check(pout[1], (en & ((8'h0f & alt[2]) | (~8'h0f & alt[1]))) | (~en & gpio[1]));
        check(pout[2], (en & alt[3]) | (~en & gpio[2]));
        check(drv[3].alt_active, {7'h00, en[0]});
        check(pout[3], {gpio[3][7:1], en[0] ? alt[0][1] : gpio[3][0]});
        check(drv[1].source_off, od[1]);
        check(drv[1].high_drive, hd[1]);
        $display("alternate functions done");
        // four toggles: two rising and two falling edges on every pin
        c_pulses = 0;
        a_pulses = 0;
        repeat (4) begin
            lvl_a <= ~lvl_a;
            lvl_c <= ~lvl_c;
            step(4);
        end
        // let the last pulse reach the monitor before counting, so the two processes never race
        step(2);
        check(8'(c_pulses), 8'h04);
        check(8'(a_pulses), 8'h02);
        $display("pin requests done");
        // shared sources: pin 7 follows the detector, pin 6 the still comparator, not the moving pin
        sel7 <= 1'b1;
        sel6 <= 1'b1;
        step(3);
        v_pulses = 0;
        k_pulses = 0;
        repeat (2) begin
            low_voltage_detector <= ~low_voltage_detector;
            lvl_a[6] <= ~lvl_a[6];
            step(4);
        end
        step(2);
        check(8'(v_pulses), 8'h01);
        check(8'(k_pulses), 8'h00);
        $display("shared sources done");
        report_and_stop();
    end
endmodule // port_pin_drive_config_test
